// [common/cbs_pkg.sv]
// How it works
// - A conversion is a charge-balance phase followed by a final-slope phase, each giving counts.
// - In charge balance the balance current fires on integrator threshold or timebase interval.
// - An 8-bit equality compare of limit and phase counter halts the converter on a match.
// - A rising final-slope line clears the phase counter and, in halt only, starts the final-slope phase.
// - The final slope ramps the integrator to zero and emits counts for the whole ramp.
// - The converter may be run through any number of successive conversions and phases.
// - The 7.68 MHz timebase is divided down to make the charge-balance intervals.
// - The undivided timebase is gated by the phase logic to form the returned counts.
// - Count pulses leave on their own output, apart from the control lines.
package cbs_pkg;

   // Clock and timebase rates.
   localparam int unsigned CLK_HZ      = 125_000_000;
   localparam int unsigned TIMEBASE_HZ = 7_680_000;
   localparam int unsigned RATE_UNIT   = 10_000;
   localparam logic [14:0] TICK_STEP   = 15'(TIMEBASE_HZ / RATE_UNIT);
   localparam logic [14:0] TICK_MOD    = 15'(CLK_HZ / RATE_UNIT);

   // Charge-balance timing, counted in timebase ticks.
   localparam int unsigned INTERVAL_TICKS = 128;
   localparam int unsigned BALANCE_TICKS  = 32;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_LIMIT  = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_BALCNT = 8'h0c;
   localparam logic [7:0] OFS_SLPCNT = 8'h10;

   // Control register fields.
   localparam int unsigned CTRL_START   = 0;
   localparam int unsigned CTRL_SLOPE   = 1;
   localparam int unsigned CTRL_SEL_LSB = 2;

   // Status register fields.
   localparam int unsigned STAT_PHASE_LSB = 0;
   localparam int unsigned STAT_CNT_LSB   = 8;

   // Reset values.
   localparam logic [7:0] LIMIT_RESET = 8'h00;
   localparam logic [1:0] SEL_RESET   = 2'h0;

   typedef enum logic [2:0] {
      CBS_IDLE,
      CBS_BALANCE,
      CBS_HALT,
      CBS_SLOPE,
      CBS_DONE
   } cbs_phase_type;

   // Lines toward the analog integrator.
   typedef struct packed {
      logic       balance_on;
      logic       slope_on;
      logic [1:0] input_sel;
   } cbs_analog_type;

endpackage

// [logic/cbs_interval_div.sv]
`timescale 1ns/1ps
`default_nettype none
module cbs_interval_div #(
   parameter int unsigned DIV = cbs_pkg::INTERVAL_TICKS
) (
   input  wire logic pclk,      // System clock.
   input  wire logic presetn,   // Asynchronous reset, active low.
   input  wire logic tick,      // Timebase enable.
   input  wire logic restart,   // Realigns the interval at a phase start.
   output logic      interval   // One-cycle interval pulse.
);

   localparam int unsigned W = $clog2(DIV);

   typedef struct packed {
      logic [W-1:0] cnt;
   } cbs_div_state_type;

   cbs_div_state_type state;
   cbs_div_state_type next_state;

   // Divide the timebase so each interval is a whole number of timebase ticks.
   always_comb begin
      next_state = state;
      if (restart) begin
         next_state.cnt = '0;
      end else if (tick) begin
         if (state.cnt == W'(DIV - 1)) begin
            next_state.cnt = '0;
         end else begin
            next_state.cnt = state.cnt + 1'b1;
         end
      end
   end

   // Tick counter register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // The pulse coincides with the closing tick, so the sequencer sees both together.
   // A registered pulse would land one clock after the tick and never be acted on.
   assign interval = tick && !restart && (state.cnt == W'(DIV - 1));

endmodule
`default_nettype wire

// [logic/cbs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer #(
   parameter int unsigned LIMIT_W   = 8,
   parameter int unsigned CNT_W     = 24,
   parameter int unsigned BAL_TICKS = cbs_pkg::BALANCE_TICKS,
   parameter int unsigned INTERVAL  = cbs_pkg::INTERVAL_TICKS
) (
   input  wire logic        pclk,            // 125 MHz system clock.
   input  wire logic        presetn,         // Asynchronous reset, active low.
   input  wire logic        psel,            // APB select.
   input  wire logic        penable,         // APB enable.
   input  wire logic        pwrite,          // APB write.
   input  wire logic [7:0]  paddr,           // APB byte address.
   input  wire logic [31:0] pwdata,          // APB write data.
   output logic      [31:0] prdata,          // APB read data.
   output logic             pready,          // APB ready.
   output logic             pslverr,         // APB error on unmapped address.
   input  wire logic        integ_threshold, // Integrator has reached its threshold.
   input  wire logic        integ_zero,      // Integrator has ramped down to zero.
   output logic             balance_on,      // Balance current switch.
   output logic             slope_on,        // Final-slope ramp current switch.
   output logic      [1:0]  input_sel,       // Converter input selector.
   output logic             count_pulse      // Gated timebase counts to the controller.
);

   localparam int unsigned BW = $clog2(BAL_TICKS + 1);

   // Conversion flow, as software sees it:
   // 1. Load the count limit, then write the control word with the start bit set.
   // 2. Balance fires a pulse on integrator threshold or on an interval, and the
   //    phase counter advances once per interval until it equals the limit.
   // 3. At a match the sequencer halts between pulses and the count stream goes quiet.
   // 4. Software raises the final-slope bit; the phase counter clears and the ramp runs.
   // 5. The ramp stops when the integrator reports zero, and the sequencer parks in done.
   // 6. Software drops the final-slope bit before the next start is accepted.
   // Both phases return counts on one pin and also total them in their own register,
   // so software may use either the pulse stream or the totals.

   // All state sits in one struct so that reset and the clock edge treat it alike.
   typedef struct packed {
      cbs_pkg::cbs_phase_type phase;
      logic [LIMIT_W-1:0]     limit;
      logic [LIMIT_W-1:0]     phase_cnt;
      logic [BW-1:0]          bal_left;
      logic                   final_slope;
      logic                   slope_prev;
      logic [CNT_W-1:0]       bal_counts;
      logic [CNT_W-1:0]       slope_counts;
      cbs_pkg::cbs_analog_type analog;
      logic                   count_pulse;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
   } cbs_seq_state_type;

   cbs_seq_state_type state;
   cbs_seq_state_type next_state;
   logic              tick;
   logic              interval;
   logic              restart;
   logic              setup;
   logic              wr_access;
   logic              mapped;
   logic              gate;

   // Returns whether a byte address hits one of the registers.
   // Anything else answers with an error and reads as zero.
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr == cbs_pkg::OFS_CTRL)   || (addr == cbs_pkg::OFS_LIMIT)  ||
                  (addr == cbs_pkg::OFS_STATUS) || (addr == cbs_pkg::OFS_BALCNT) ||
                  (addr == cbs_pkg::OFS_SLPCNT);
   endfunction

   // Fractional divider turning the system clock into the 7.68 MHz timebase.
   cbs_tick_gen u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick)
   );

   // Interval divider realigned at every charge-balance start.
   cbs_interval_div #(
      .DIV (INTERVAL)
   ) u_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .tick     (tick),
      .restart  (restart),
      .interval (interval)
   );

   // Bus qualifiers; the slave answers in the access cycle right after setup.
   assign setup     = psel && !penable;
   assign wr_access = psel && penable && pwrite && state.pready;
   assign mapped    = is_mapped(paddr);
   assign restart   = wr_access && (paddr == cbs_pkg::OFS_CTRL) &&
                      pwdata[cbs_pkg::CTRL_START] && !pwdata[cbs_pkg::CTRL_SLOPE] &&
                      !state.final_slope;

   // Counts flow only while the balance current is on or the final slope runs.
   // The cycle that sees zero is shut out, so the pin and the slope total agree.
   assign gate = (state.phase == cbs_pkg::CBS_BALANCE && state.bal_left != '0) ||
                 (state.phase == cbs_pkg::CBS_SLOPE && !integ_zero);

   // Next-state logic for the bus, the registers and the phase machine. Later blocks
   // in this process override earlier ones, so a start write wins over any phase event
   // that falls in the same cycle.
   always_comb begin
      next_state = state;
      next_state.slope_prev  = state.final_slope;
      next_state.count_pulse = tick && gate;
      next_state.pready      = setup;
      next_state.pslverr     = setup && !mapped;

      // Register reads are captured in setup so prdata comes from a flop in access.
      if (setup && !pwrite) begin
         unique case (paddr)
            cbs_pkg::OFS_CTRL: begin
               next_state.prdata = 32'h0000_0000;
               next_state.prdata[cbs_pkg::CTRL_SLOPE] = state.final_slope;
               next_state.prdata[cbs_pkg::CTRL_SEL_LSB +: 2] = state.analog.input_sel;
            end
            cbs_pkg::OFS_LIMIT:  next_state.prdata = 32'(state.limit);
            cbs_pkg::OFS_STATUS: begin
               next_state.prdata = 32'h0000_0000;
               next_state.prdata[cbs_pkg::STAT_PHASE_LSB +: 3] = state.phase;
               next_state.prdata[cbs_pkg::STAT_CNT_LSB +: LIMIT_W] = state.phase_cnt;
            end
            cbs_pkg::OFS_BALCNT: next_state.prdata = 32'(state.bal_counts);
            cbs_pkg::OFS_SLPCNT: next_state.prdata = 32'(state.slope_counts);
            default:             next_state.prdata = 32'h0000_0000;
         endcase
      end

      // Register writes take effect at the access edge; unmapped writes are dropped.
      if (wr_access) begin
         if (paddr == cbs_pkg::OFS_CTRL) begin
            next_state.final_slope      = pwdata[cbs_pkg::CTRL_SLOPE];
            next_state.analog.input_sel = pwdata[cbs_pkg::CTRL_SEL_LSB +: 2];
         end
         if (paddr == cbs_pkg::OFS_LIMIT) begin
            next_state.limit = pwdata[LIMIT_W-1:0];
         end
      end

      // Phase sequencing.
      unique case (state.phase)
         cbs_pkg::CBS_IDLE, cbs_pkg::CBS_DONE: begin
            // Idle and done keep both currents off.
            next_state.analog.balance_on = 1'b0;
            next_state.analog.slope_on   = 1'b0;
         end
         cbs_pkg::CBS_BALANCE: begin
            if (tick) begin
               if (state.bal_left != '0) begin
                  next_state.bal_left = state.bal_left - 1'b1;
               end else if (state.phase_cnt == state.limit) begin
                  // Halt only between balance pulses so no pulse is cut short.
                  next_state.phase = cbs_pkg::CBS_HALT;
               end else if (integ_threshold || interval) begin
                  next_state.bal_left = BW'(BAL_TICKS);
               end
               // The counter stops at the limit, so a late interval cannot carry it past
               // the match and hide the halt from the comparator.
               if (interval && state.phase_cnt != state.limit) begin
                  next_state.phase_cnt = state.phase_cnt + 1'b1;
               end
            end
            if (tick && gate) begin
               next_state.bal_counts = state.bal_counts + 1'b1;
            end
            next_state.analog.balance_on = (next_state.bal_left != '0);
         end
         cbs_pkg::CBS_HALT: begin
            // Halted: no current flows and the gate stays shut until software acts.
            next_state.analog.balance_on = 1'b0;
         end
         cbs_pkg::CBS_SLOPE: begin
            // Zero ends the ramp at once; a tick in that cycle is not counted.
            if (integ_zero) begin
               next_state.phase = cbs_pkg::CBS_DONE;
               next_state.analog.slope_on = 1'b0;
            end else if (tick) begin
               next_state.slope_counts = state.slope_counts + 1'b1;
            end
         end
         default: begin
            next_state.phase = cbs_pkg::CBS_IDLE;
         end
      endcase

      // A rising final-slope line clears the counter and starts the ramp.
      // A rise outside halt only clears the counter; the ramp never starts mid-balance.
      if (state.final_slope && !state.slope_prev) begin
         next_state.phase_cnt = '0;
         if (state.phase == cbs_pkg::CBS_HALT) begin
            next_state.phase           = cbs_pkg::CBS_SLOPE;
            next_state.slope_counts    = '0;
            next_state.analog.slope_on = 1'b1;
         end
      end

      // Start of a conversion; any number may follow one another.
      // It is refused while the final-slope bit is set, which keeps the phases in order.
      if (restart) begin
         next_state.phase             = cbs_pkg::CBS_BALANCE;
         next_state.phase_cnt         = '0;
         next_state.bal_left          = '0;
         next_state.bal_counts        = '0;
         next_state.analog.balance_on = 1'b0;
         next_state.analog.slope_on   = 1'b0;
      end
   end

   // State register. Reset parks the sequencer idle with the limit and the input
   // selection at their reset values; totals and the phase counter read zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state                  <= '0;
         state.phase            <= cbs_pkg::CBS_IDLE;
         state.limit            <= cbs_pkg::LIMIT_RESET;
         state.analog.input_sel <= cbs_pkg::SEL_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Every output is a field of the state register.
   assign prdata      = state.prdata;
   assign pready      = state.pready;
   assign pslverr     = state.pslverr;
   assign balance_on  = state.analog.balance_on;
   assign slope_on    = state.analog.slope_on;
   assign input_sel   = state.analog.input_sel;
   assign count_pulse = state.count_pulse;

endmodule
`default_nettype wire

// [logic/cbs_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module cbs_tick_gen (
   input  wire logic pclk,      // System clock.
   input  wire logic presetn,   // Asynchronous reset, active low.
   output logic      tick       // One-cycle timebase enable.
);

   typedef struct packed {
      logic [14:0] acc;
      logic        tick;
   } cbs_tick_state_type;

   cbs_tick_state_type state;
   cbs_tick_state_type next_state;
   logic [14:0]        sum;

   // A phase accumulator keeps the exact average timebase rate; ticks jitter by one clock.
   always_comb begin
      next_state = state;
      sum = state.acc + cbs_pkg::TICK_STEP;
      if (sum >= cbs_pkg::TICK_MOD) begin
         next_state.acc  = sum - cbs_pkg::TICK_MOD;
         next_state.tick = 1'b1;
      end else begin
         next_state.acc  = sum;
         next_state.tick = 1'b0;
      end
   end

   // Accumulator and tick register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // The tick leaves straight from its flip-flop.
   assign tick = state.tick;

endmodule
`default_nettype wire

// [testbench/cbs_integ_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cbs_integ_model (
   input  wire logic       pclk,            // Clock.
   input  wire logic       presetn,         // Reset, active low.
   input  wire logic [7:0] ramp_len,        // Cycles to threshold, 0 never.
   input  wire logic [7:0] zero_after,      // Slope counts to reach zero.
   input  wire logic       balance_on,      // Balance switch.
   input  wire logic       slope_on,        // Slope switch.
   input  wire logic       count_pulse,     // Counts.
   output logic            integ_threshold, // Threshold reached.
   output logic            integ_zero       // Ramped to zero.
);
   logic [7:0] ramp;
   logic [7:0] cnt;
   // The integrator climbs while no current is switched in; a slow ramp lets intervals win.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp <= 8'h00;
         cnt  <= 8'h00;
      end else begin
         ramp <= (balance_on || slope_on || ramp == 8'hff) ? 8'h00 : ramp + 8'h01;
         cnt  <= slope_on ? cnt + 8'(count_pulse) : 8'h00;
      end
   end
   // Comparators seen by the converter.
   assign integ_threshold = (ramp_len != 8'h00) && (ramp >= ramp_len);
   assign integ_zero      = slope_on && (cnt >= zero_after);
endmodule
`default_nettype wire

// [testbench/cbs_sequencer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer_assertions (
   input wire logic        pclk,        // Clock.
   input wire logic        presetn,     // Reset, active low.
   input wire logic        psel,        // APB select.
   input wire logic        penable,     // APB enable.
   input wire logic        pwrite,      // APB write.
   input wire logic [7:0]  paddr,       // APB address.
   input wire logic [31:0] pwdata,      // APB write data.
   input wire logic        pready,      // APB ready.
   input wire logic        pslverr,     // APB error.
   input wire logic        integ_zero,  // Integrator at zero.
   input wire logic        balance_on,  // Balance switch.
   input wire logic        slope_on,    // Slope switch.
   input wire logic        count_pulse  // Counts.
);
   logic wr_slope;
   // A control write that raises the final-slope bit.
   assign wr_slope = psel && penable && pwrite && (paddr == 8'h00) && pwdata[1];
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Bus timing: one access cycle, always answered.
   property p_rdy; psel && !penable |=> pready; endproperty
   property p_rdy_only; pready |-> psel && penable && $past(psel && !penable); endproperty
   property p_err; pslverr |-> pready; endproperty
   // Counts are short pulses and only come from a running phase.
   property p_short; count_pulse |=> !count_pulse; endproperty
   property p_gated;
      count_pulse |-> balance_on || slope_on || $past(balance_on) || $past(slope_on);
   endproperty
   property p_excl; !(balance_on && slope_on); endproperty
   property p_bal_cnt; $rose(balance_on) |-> ##[0:40] count_pulse; endproperty
   // The final slope starts only from software and stops at zero, then stays quiet.
   property p_slope_go; $rose(slope_on) |-> $past(wr_slope) || $past(wr_slope, 2); endproperty
   property p_slope_end; slope_on && integ_zero |-> ##[1:40] !slope_on; endproperty
   property p_quiet; $fell(slope_on) |-> ##2 (!count_pulse) [*8]; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   a_rdy_only: assert property (p_rdy_only) else $error("stray ready");
   a_err: assert property (p_err) else $error("error without ready");
   a_short: assert property (p_short) else $error("count too long");
   a_gated: assert property (p_gated) else $error("count while stopped");
   a_excl: assert property (p_excl) else $error("both currents on");
   a_bal_cnt: assert property (p_bal_cnt) else $error("balance without counts");
   a_slope_go: assert property (p_slope_go) else $error("slope not from write");
   a_slope_end: assert property (p_slope_end) else $error("slope not stopped");
   a_quiet: assert property (p_quiet) else $error("count after slope");
   c_slope: cover property ($rose(slope_on));
   c_bal: cover property ($rose(balance_on));
   c_err: cover property (pslverr);
endmodule
bind cbs_sequencer cbs_sequencer_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .integ_zero, .balance_on, .slope_on, .count_pulse);
`default_nettype wire

// [testbench/cbs_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer_tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        integ_threshold;
   logic        integ_zero;
   logic        balance_on;
   logic        slope_on;
   logic [1:0]  input_sel;
   logic        count_pulse;
   logic [7:0]  ramp_len;
   logic [7:0]  zero_after;
   logic [31:0] rd;
   logic        err;
   int          bad_count;
   int          checked;
   int          seen;
   int          lim_q[$];
   localparam int BAL = 4;
   cbs_sequencer #(.BAL_TICKS(BAL), .INTERVAL(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .integ_threshold, .integ_zero, .balance_on,
      .slope_on, .input_sel, .count_pulse);
   cbs_integ_model u_integ (.pclk, .presetn, .ramp_len, .zero_after, .balance_on, .slope_on,
      .count_pulse, .integ_threshold, .integ_zero);
   // Clock and a running tally of returned counts.
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (count_pulse === 1'b1) seen++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus transfer; the request holds until ready is seen.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_phase(input logic [2:0] p);
      int n;
      n = 0;
      do begin
         apb(1'b0, cbs_pkg::OFS_STATUS, 32'h0);
         n++;
      end while (rd[2:0] !== p && n < 400);
      check({29'h0, rd[2:0]}, {29'h0, p});
   endtask
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Main sequence: reset, a refused write and a refused read, then one conversion per input selection.
   initial begin
      logic [7:0] lim;
      int         bal;
      int         zn;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ramp_len = 8'h00;
      zero_after = 8'h05;
      void'($urandom(58));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, cbs_pkg::OFS_LIMIT, 32'h0);
      check(rd, {24'h0, cbs_pkg::LIMIT_RESET});
      apb(1'b1, 8'h14, 32'hffffffff);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 8'h14, 32'h0);
      check(rd, 32'h0);
      check({31'h0, err}, 32'h1);
      $display("Test reset done");
      for (int i = 0; i < 4; i++) begin
         lim = 8'($urandom_range(3));
         zn = $urandom_range(12, 1);
         ramp_len <= i[0] ? 8'h00 : 8'($urandom_range(40, 10));
         zero_after <= 8'(zn);
         apb(1'b1, cbs_pkg::OFS_LIMIT, {24'h0, lim});
         lim_q.push_back(lim);
         apb(1'b0, cbs_pkg::OFS_LIMIT, 32'h0);
         check(rd, {24'h0, 8'(lim_q.pop_front())});
         seen = 0;
         apb(1'b1, cbs_pkg::OFS_CTRL, {28'h0, 2'(i), 2'b01});
         wait_phase(3'd2);
         check({24'h0, rd[15:8]}, {24'h0, lim});
         check({30'h0, input_sel}, 32'(i));
         bal = seen;
         if (i[0]) begin
            check(32'(bal), 32'(BAL * lim));
         end else begin
            check(32'(bal % BAL), 32'h0);
         end
         repeat (60) @(posedge pclk);
         check(32'(seen), 32'(bal));
         apb(1'b0, cbs_pkg::OFS_BALCNT, 32'h0);
         check(rd, 32'(bal));
         seen = 0;
         apb(1'b1, cbs_pkg::OFS_CTRL, {28'h0, 2'(i), 2'b10});
         apb(1'b0, cbs_pkg::OFS_STATUS, 32'h0);
         check({21'h0, rd[15:8], rd[2:0]}, 32'h3);
         wait_phase(3'd4);
         check(32'(seen), 32'(zn));
         apb(1'b0, cbs_pkg::OFS_CTRL, 32'h0);
         check(rd, {28'h0, 2'(i), 2'b10});
         apb(1'b0, cbs_pkg::OFS_SLPCNT, 32'h0);
         check(rd, 32'(zn));
         apb(1'b1, cbs_pkg::OFS_CTRL, {28'h0, 2'(i), 2'b00});
         $display("Test conversion %0d done", i);
      end
      end_sim();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      #600000;
      bad_count++;
      end_sim();
   end
endmodule
`default_nettype wire
